// >>> design/ccsp_device.sv
// Converter end of the configuration serial port with its register space
// Functional notes
// - Select low frames; high ignores clock, data
// - Select fall plus first rise starts frame
// - Incoming bits sampled on rising clock edges
// - Sixteen instruction bits precede any data
// - Two length bits give bytes, minimum one
// - Data moves in bytes, one register each
// - Leading instruction bit selects read, turns line
// - Drive after falling edge, release after rising
// - Data most significant first until configuration changes; instruction always
// - Reset low restores default configuration
// - Select grounded at power-up disables port
// - Data strap high enables duty stabilizer
// - Clock strap high selects twos complement
// - Straps taken from levels at power-on
// - Critical registers reset; others keep values
// - Program values apply on update transfer bit
`timescale 1ns/10ps
`default_nettype none
module ccsp_device
  import ccsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  ccsp_if.device link,
  output logic duty_stabilizer_select,
  output logic number_format_select,
  output logic [7:0] active_modes,
  output logic strap_mode,
  output logic frame_active
);
  logic csn_s1_ff, csn_s2_ff, csn_s3_ff;
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic sdio_s1_ff, sdio_s2_ff;
  logic [1:0] strap_cnt_ff;
  logic strap_done_ff, strap_mode_ff, strap_stab_ff, strap_fmt_ff;
  ccsp_dev_state_e state_ff;
  logic [3:0] bit_cnt_ff;
  logic [15:0] instr_sr_ff;
  logic rw_ff;
  logic [1:0] bytes_left_ff;
  logic [7:0] addr_ff;
  logic [7:0] data_sr_ff;
  logic io_o_ff, io_oe_ff;
  logic [7:0] port_cfg_ff;
  logic [7:0] shd_modes_ff, shd_clock_ff, shd_format_ff;
  logic [7:0] act_modes_ff, act_clock_ff, act_format_ff;
  logic [7:0] mem_ff [0:255];
  logic stab_out_ff, fmt_out_ff;

  // Edge detectors look only at the second and third stages
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      csn_s1_ff <= 1'b1;
      csn_s2_ff <= 1'b1;
      csn_s3_ff <= 1'b1;
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      sdio_s1_ff <= 1'b0;
      sdio_s2_ff <= 1'b0;
    end else begin
      csn_s1_ff <= link.port_select_n;
      csn_s2_ff <= csn_s1_ff;
      csn_s3_ff <= csn_s2_ff;
      sclk_s1_ff <= link.serial_clock_format_strap;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      sdio_s1_ff <= link.serial_io_stabilizer_strap;
      sdio_s2_ff <= sdio_s1_ff;
    end
  end

  wire sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
  wire sclk_fall = ~sclk_s2_ff & sclk_s3_ff;
  wire csn_fall = ~csn_s2_ff & csn_s3_ff;
  wire live = ~csn_s2_ff & strap_done_ff & ~strap_mode_ff;
  wire lsb_first = port_cfg_ff[CFG_LSB_HI] | port_cfg_ff[CFG_LSB_LO];
  wire [2:0] bit_idx = lsb_first ? bit_cnt_ff[2:0] : ~bit_cnt_ff[2:0];
  wire [15:0] nxt_instr = {instr_sr_ff[14:0], sdio_s2_ff};
  wire in_data = (state_ff == DS_DATA) & live;
  wire last_bit = (bit_cnt_ff[2:0] == 3'h7);
  wire wr_en = in_data & sclk_rise & last_bit & ~rw_ff;
  wire [7:0] bit_mask = 8'h01 << bit_idx;
  wire [7:0] wr_byte = sdio_s2_ff ? (data_sr_ff | bit_mask) : (data_sr_ff & ~bit_mask);
  wire soft_reset = wr_en & (addr_ff == ADDR_PORT_CFG) &
                    (wr_byte[CFG_SOFT_HI] | wr_byte[CFG_SOFT_LO]);
  wire xfer = wr_en & (addr_ff == ADDR_UPDATE) & wr_byte[UPD_XFER_BIT];
  wire [7:0] rd_data =
    (addr_ff == ADDR_PORT_CFG) ? port_cfg_ff :
    (addr_ff == ADDR_CHIP_ID) ? CHIP_ID_VALUE :
    (addr_ff == ADDR_CHIP_GRADE) ? CHIP_GRADE_VALUE :
    (addr_ff == ADDR_MODES) ? shd_modes_ff :
    (addr_ff == ADDR_CLOCK) ? shd_clock_ff :
    (addr_ff == ADDR_FORMAT) ? shd_format_ff :
    (addr_ff == ADDR_UPDATE) ? 8'h00 : mem_ff[addr_ff];

  // Straps are caught once the synchronisers have settled after release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      strap_mode_ff <= 1'b0;
      strap_stab_ff <= 1'b0;
      strap_fmt_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == STRAP_CAPTURE_CYC) begin
        strap_done_ff <= 1'b1;
        strap_mode_ff <= ~csn_s2_ff;
        strap_stab_ff <= sdio_s2_ff;
        strap_fmt_ff <= sclk_s2_ff;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= DS_IDLE;
      bit_cnt_ff <= 4'h0;
      instr_sr_ff <= 16'h0000;
      rw_ff <= 1'b0;
      bytes_left_ff <= 2'h0;
      addr_ff <= 8'h00;
      data_sr_ff <= 8'h00;
    end else if (!live) begin
      state_ff <= DS_IDLE;
      bit_cnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        DS_IDLE: begin
          if (csn_fall) begin
            state_ff <= DS_INSTR;
            bit_cnt_ff <= 4'h0;
          end
        end
        DS_INSTR: begin
          if (sclk_rise) begin
            instr_sr_ff <= nxt_instr;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'(INSTR_BITS - 1)) begin
              state_ff <= DS_DATA;
              bit_cnt_ff <= 4'h0;
              rw_ff <= nxt_instr[INSTR_RW_BIT];
              bytes_left_ff <= nxt_instr[INSTR_LEN_HI:INSTR_LEN_LO];
              addr_ff <= nxt_instr[7:0];
              data_sr_ff <= 8'h00;
            end
          end
        end
        DS_DATA: begin
          if (sclk_rise) begin
            data_sr_ff <= wr_byte;
            bit_cnt_ff <= {1'b0, bit_cnt_ff[2:0] + 3'h1};
            if (last_bit) begin
              addr_ff <= addr_ff + 8'h01;
              if (bytes_left_ff == 2'h0) begin
                state_ff <= DS_DONE;
              end else begin
                bytes_left_ff <= bytes_left_ff - 2'h1;
              end
            end
          end
        end
        DS_DONE: begin
          state_ff <= DS_DONE;
        end
        default: begin
          state_ff <= DS_IDLE;
        end
      endcase
    end
  end

  // Line turns only in the read data phase
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      io_o_ff <= 1'b0;
      io_oe_ff <= 1'b0;
    end else if (!in_data || !rw_ff) begin
      io_oe_ff <= 1'b0;
    end else if (sclk_fall) begin
      io_oe_ff <= 1'b1;
      io_o_ff <= rd_data[bit_idx];
    end else if (sclk_rise && last_bit && bytes_left_ff == 2'h0) begin
      io_oe_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port_cfg_ff <= RST_PORT_CFG;
      shd_modes_ff <= RST_MODES;
      shd_clock_ff <= RST_CLOCK;
      shd_format_ff <= RST_FORMAT;
      act_modes_ff <= RST_MODES;
      act_clock_ff <= RST_CLOCK;
      act_format_ff <= RST_FORMAT;
    end else if (soft_reset) begin
      port_cfg_ff <= RST_PORT_CFG;
      shd_modes_ff <= RST_MODES;
      shd_clock_ff <= RST_CLOCK;
      shd_format_ff <= RST_FORMAT;
      act_modes_ff <= RST_MODES;
      act_clock_ff <= RST_CLOCK;
      act_format_ff <= RST_FORMAT;
    end else if (wr_en) begin
      if (addr_ff == ADDR_PORT_CFG) begin
        port_cfg_ff <= wr_byte;
      end
      if (addr_ff == ADDR_MODES) begin
        shd_modes_ff <= wr_byte;
      end
      if (addr_ff == ADDR_CLOCK) begin
        shd_clock_ff <= wr_byte;
      end
      if (addr_ff == ADDR_FORMAT) begin
        shd_format_ff <= wr_byte;
      end
      if (xfer) begin
        act_modes_ff <= shd_modes_ff;
        act_clock_ff <= shd_clock_ff;
        act_format_ff <= shd_format_ff;
      end
    end
  end

  // Non-critical locations have no reset so they survive it
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_ff[addr_ff] <= wr_byte;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stab_out_ff <= RST_CLOCK[CLK_STAB_BIT];
      fmt_out_ff <= RST_FORMAT[FMT_TWOS_BIT];
    end else if (strap_done_ff && strap_mode_ff) begin
      stab_out_ff <= strap_stab_ff;
      fmt_out_ff <= strap_fmt_ff;
    end else begin
      stab_out_ff <= act_clock_ff[CLK_STAB_BIT];
      fmt_out_ff <= act_format_ff[FMT_TWOS_BIT];
    end
  end

  assign link.dev_io_o = io_o_ff;
  assign link.dev_io_oe = io_oe_ff;
  assign duty_stabilizer_select = stab_out_ff;
  assign number_format_select = fmt_out_ff;
  assign active_modes = act_modes_ff;
  assign strap_mode = strap_mode_ff;
  assign frame_active = (state_ff != DS_IDLE);
endmodule : ccsp_device
`default_nettype wire

// >>> design/ccsp_if.sv
// Three-wire link between programming master and converter port
`timescale 1ns/10ps
`default_nettype none
interface ccsp_if #(parameter logic PULL_LEVEL = 1'b0);
  logic port_select_n;
  logic serial_clock_format_strap;
  logic mst_io_o;
  logic mst_io_oe;
  logic dev_io_o;
  logic dev_io_oe;
  logic serial_io_stabilizer_strap;
  // Resistor level wins when nobody drives
  assign serial_io_stabilizer_strap = mst_io_oe ? mst_io_o : (dev_io_oe ? dev_io_o : PULL_LEVEL);
  modport master (
    output port_select_n,
    output serial_clock_format_strap,
    output mst_io_o,
    output mst_io_oe,
    input serial_io_stabilizer_strap
  );
  modport device (
    input port_select_n,
    input serial_clock_format_strap,
    input serial_io_stabilizer_strap,
    output dev_io_o,
    output dev_io_oe
  );
endinterface : ccsp_if
`default_nettype wire

// >>> design/ccsp_master.sv
// Programming master end: frames instruction and data bytes on the link
`timescale 1ns/10ps
`default_nettype none
module ccsp_master
  import ccsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  ccsp_if.master link,
  input wire logic start,
  input wire logic rd_not_wr,
  input wire logic [1:0] length_code,
  input wire logic [7:0] start_addr,
  input wire logic [31:0] wr_data,
  input wire logic lsb_first,
  input wire logic strap_mode,
  input wire logic strap_stabilizer,
  input wire logic strap_format,
  output logic busy,
  output logic done,
  output logic [31:0] rd_data
);
  ccsp_mst_state_e state_ff;
  logic [3:0] tick_ff;
  logic [5:0] bit_ff;
  logic [15:0] instr_ff;
  logic [31:0] wdat_ff;
  logic lsb_ff;
  logic csn_ff, sclk_ff, io_o_ff, io_oe_ff, done_ff;
  logic [31:0] rdat_ff;
  logic io_s1_ff, io_s2_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      io_s1_ff <= 1'b0;
      io_s2_ff <= 1'b0;
    end else begin
      io_s1_ff <= link.serial_io_stabilizer_strap;
      io_s2_ff <= io_s1_ff;
    end
  end

  wire half_done = (tick_ff == 4'(SCLK_HALF_CYC - 1));
  wire [5:0] last_bit = 6'(INSTR_BITS) + {1'b0, instr_ff[INSTR_LEN_HI:INSTR_LEN_LO], 3'h7};
  wire [5:0] nxt_bit = bit_ff + 6'h01;
  wire in_instr = (nxt_bit < 6'(INSTR_BITS));
  wire [5:0] dpos = nxt_bit - 6'(INSTR_BITS);
  wire [2:0] didx = lsb_ff ? dpos[2:0] : ~dpos[2:0];
  wire [4:0] dsel = {dpos[4:3], didx};
  wire [3:0] isel = ~nxt_bit[3:0];
  wire nxt_out = in_instr ? instr_ff[isel] : wdat_ff[dsel];
  wire [5:0] cur_pos = bit_ff - 6'(INSTR_BITS);
  wire [4:0] csel = {cur_pos[4:3], lsb_ff ? cur_pos[2:0] : ~cur_pos[2:0]};
  wire is_read = instr_ff[INSTR_RW_BIT];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= MS_IDLE;
      tick_ff <= 4'h0;
      bit_ff <= 6'h00;
      instr_ff <= 16'h0000;
      wdat_ff <= 32'h00000000;
      lsb_ff <= 1'b0;
      csn_ff <= 1'b1;
      sclk_ff <= 1'b0;
      io_o_ff <= 1'b0;
      io_oe_ff <= 1'b0;
      done_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      done_ff <= 1'b0;
      tick_ff <= half_done ? 4'h0 : tick_ff + 4'h1;
      case (state_ff)
        MS_IDLE: begin
          tick_ff <= 4'h0;
          if (strap_mode) begin
            csn_ff <= 1'b0;
            sclk_ff <= strap_format;
            io_o_ff <= strap_stabilizer;
            io_oe_ff <= 1'b1;
          end else begin
            csn_ff <= 1'b1;
            sclk_ff <= 1'b0;
            io_oe_ff <= 1'b0;
            if (start) begin
              instr_ff <= {rd_not_wr, length_code, 5'h00, start_addr};
              wdat_ff <= wr_data;
              lsb_ff <= lsb_first;
              csn_ff <= 1'b0;
              io_oe_ff <= 1'b1;
              io_o_ff <= rd_not_wr;
              bit_ff <= 6'h00;
              state_ff <= MS_SETUP;
            end
          end
        end
        MS_SETUP: begin
          if (half_done) begin
            state_ff <= MS_LOW;
          end
        end
        MS_LOW: begin
          if (half_done) begin
            // Read bits are taken at the rise, before the device lets go
            if (!(bit_ff < 6'(INSTR_BITS)) && is_read) begin
              rdat_ff[csel] <= io_s2_ff;
            end
            sclk_ff <= 1'b1;
            state_ff <= MS_HIGH;
          end
        end
        MS_HIGH: begin
          if (half_done) begin
            sclk_ff <= 1'b0;
            if (bit_ff == last_bit) begin
              io_oe_ff <= 1'b0;
              state_ff <= MS_HOLD;
            end else begin
              bit_ff <= nxt_bit;
              io_o_ff <= nxt_out;
              io_oe_ff <= in_instr | ~is_read;
              state_ff <= MS_LOW;
            end
          end
        end
        MS_HOLD: begin
          if (half_done) begin
            csn_ff <= 1'b1;
            done_ff <= 1'b1;
            state_ff <= MS_IDLE;
          end
        end
        default: begin
          state_ff <= MS_IDLE;
        end
      endcase
    end
  end

  assign link.port_select_n = csn_ff;
  assign link.serial_clock_format_strap = sclk_ff;
  assign link.mst_io_o = io_o_ff;
  assign link.mst_io_oe = io_oe_ff;
  assign busy = (state_ff != MS_IDLE);
  assign done = done_ff;
  assign rd_data = rdat_ff;
endmodule : ccsp_master
`default_nettype wire

// >>> design/ccsp_pkg.sv
// Shared constants and types for the converter configuration serial port
package ccsp_pkg;
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int INSTR_RW_BIT = 15;
  localparam int INSTR_LEN_HI = 14;
  localparam int INSTR_LEN_LO = 13;
  localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
  localparam logic [7:0] ADDR_CHIP_ID = 8'h01;
  localparam logic [7:0] ADDR_CHIP_GRADE = 8'h02;
  localparam logic [7:0] ADDR_MODES = 8'h08;
  localparam logic [7:0] ADDR_CLOCK = 8'h09;
  localparam logic [7:0] ADDR_FORMAT = 8'h14;
  localparam logic [7:0] ADDR_UPDATE = 8'hff;
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_MODES = 8'h00;
  localparam logic [7:0] RST_CLOCK = 8'h01;
  localparam logic [7:0] RST_FORMAT = 8'h00;
  // Arbitrary identification value
  localparam logic [7:0] CHIP_ID_VALUE = 8'h5a;
  localparam logic [7:0] CHIP_GRADE_VALUE = 8'h00;
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_SOFT_HI = 5;
  localparam int CFG_SOFT_LO = 2;
  localparam int CFG_LSB_LO = 1;
  localparam int UPD_XFER_BIT = 0;
  localparam int CLK_STAB_BIT = 0;
  localparam int FMT_TWOS_BIT = 0;
  localparam int CORE_PERIOD_NS = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
  localparam logic [1:0] STRAP_CAPTURE_CYC = 2'h3;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_INSTR = 2'b01,
    DS_DATA = 2'b10,
    DS_DONE = 2'b11
  } ccsp_dev_state_e;
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_SETUP = 3'b001,
    MS_LOW = 3'b010,
    MS_HIGH = 3'b011,
    MS_HOLD = 3'b100
  } ccsp_mst_state_e;
endpackage : ccsp_pkg

// >>> tb/ccsp_bench.sv
// Self-checking bench: master and device joined, plus a strapped pair
`timescale 1ns/10ps
`default_nettype none
module ccsp_bench
  import ccsp_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic rd_not_wr = 1'b0;
  logic [1:0] length_code = 2'h0;
  logic [7:0] start_addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic lsb_first = 1'b0;
  logic s_stab = 1'b0;
  logic s_fmt = 1'b1;
  logic dss, nfs, smode, busy, done, dss_b, nfs_b, smode_b, fa;
  logic [7:0] modes;
  logic [31:0] rd_data;
  int err_total = 0;
  int total_checks = 0;

  always #5 core_clk = ~core_clk;

  ccsp_if #(.PULL_LEVEL(1'b0)) link_a ();
  ccsp_if #(.PULL_LEVEL(1'b0)) link_b ();

  ccsp_master ccsp_master_i (.core_clk(core_clk), .resetn(resetn), .link(link_a),
    .start(start), .rd_not_wr(rd_not_wr), .length_code(length_code),
    .start_addr(start_addr), .wr_data(wr_data), .lsb_first(lsb_first), .strap_mode(1'b0),
    .strap_stabilizer(s_stab), .strap_format(s_fmt), .busy(busy), .done(done),
    .rd_data(rd_data));
  ccsp_device ccsp_device_i (.core_clk(core_clk), .resetn(resetn), .link(link_a),
    .duty_stabilizer_select(dss), .number_format_select(nfs), .active_modes(modes),
    .strap_mode(smode), .frame_active(fa));
  // Second pair powers up strapped; its master ignores start there
  ccsp_master ccsp_master_strap_i (.core_clk(core_clk), .resetn(resetn), .link(link_b),
    .start(start), .rd_not_wr(rd_not_wr), .length_code(length_code),
    .start_addr(start_addr), .wr_data(wr_data), .lsb_first(lsb_first), .strap_mode(1'b1),
    .strap_stabilizer(s_stab), .strap_format(s_fmt), .busy(), .done(), .rd_data());
  ccsp_device ccsp_device_strap_i (.core_clk(core_clk), .resetn(resetn), .link(link_b),
    .duty_stabilizer_select(dss_b), .number_format_select(nfs_b), .active_modes(),
    .strap_mode(smode_b), .frame_active());

  ccsp_link_props ccsp_link_props_i (.core_clk(core_clk), .resetn(resetn),
    .port_select_n(link_a.port_select_n),
    .serial_clock_format_strap(link_a.serial_clock_format_strap),
    .mst_io_o(link_a.mst_io_o), .mst_io_oe(link_a.mst_io_oe),
    .dev_io_o(link_a.dev_io_o), .dev_io_oe(link_a.dev_io_oe),
    .serial_io_stabilizer_strap(link_a.serial_io_stabilizer_strap));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Straps must stand still through capture, so they change before reset
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (12) @(posedge core_clk);
  endtask : do_reset

  task automatic xfer(input logic rd, input logic [1:0] len, input logic [7:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    // Device needs a few cycles to see select high and go idle
    repeat (4) @(negedge core_clk);
    chk("frame_idle", 1'b0, fa);
    @(posedge core_clk);
    start <= 1'b1;
    rd_not_wr <= rd;
    length_code <= len;
    start_addr <= a;
    wr_data <= wd;
    @(posedge core_clk);
    start <= 1'b0;
    @(negedge core_clk);
    chk("busy", 1'b1, busy);
    while (done !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      err_total++;
      $display("MISMATCH done expected 1 seen %b", done);
    end else begin
      chk("frame_end", 1'b1, fa);
      chk("busy_end", 1'b0, busy);
    end
  endtask : xfer

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    do_reset();
    chk("stab", 1'b1, dss);
    chk("fmt", 1'b0, nfs);
    chk("modes", 8'h00, modes);
    chk("smode", 1'b0, smode);
    chk("b_smode", 1'b1, smode_b);
    chk("b_stab", 1'b0, dss_b);
    chk("b_fmt", 1'b1, nfs_b);
    xfer(1'b1, 2'h0, ADDR_CHIP_ID, 32'h0);
    chk("id", CHIP_ID_VALUE, rd_data[7:0]);
    xfer(1'b1, 2'h0, ADDR_PORT_CFG, 32'h0);
    chk("cfg", RST_PORT_CFG, rd_data[7:0]);
    xfer(1'b0, 2'h1, ADDR_MODES, 32'h0000_0003);
    chk("modes_held", 8'h00, modes);
    chk("stab_held", 1'b1, dss);
    xfer(1'b1, 2'h1, ADDR_MODES, 32'h0);
    chk("shadow", 16'h0003, rd_data[15:0]);
    xfer(1'b0, 2'h0, ADDR_FORMAT, 32'h1);
    xfer(1'b0, 2'h0, ADDR_UPDATE, 32'h1);
    chk("modes_upd", 8'h03, modes);
    chk("stab_upd", 1'b0, dss);
    chk("fmt_upd", 1'b1, nfs);
    xfer(1'b0, 2'h3, 8'h20, 32'hdead_beef);
    xfer(1'b1, 2'h3, 8'h20, 32'h0);
    chk("four_bytes", 32'hdead_beef, rd_data);
    // Mirrored nibbles so the setting lands whichever order is live
    xfer(1'b0, 2'h0, ADDR_PORT_CFG, 32'h5a);
    @(posedge core_clk);
    lsb_first <= 1'b1;
    xfer(1'b1, 2'h0, 8'h20, 32'h0);
    chk("lsb_rd", 8'hef, rd_data[7:0]);
    @(posedge core_clk);
    lsb_first <= 1'b0;
    xfer(1'b1, 2'h0, 8'h20, 32'h0);
    chk("rev_rd", 8'hf7, rd_data[7:0]);
    @(posedge core_clk);
    s_stab <= 1'b1;
    s_fmt <= 1'b0;
    do_reset();
    chk("rst_stab", 1'b1, dss);
    chk("rst_fmt", 1'b0, nfs);
    chk("rst_modes", 8'h00, modes);
    chk("b_stab2", 1'b1, dss_b);
    chk("b_fmt2", 1'b0, nfs_b);
    xfer(1'b1, 2'h0, ADDR_PORT_CFG, 32'h0);
    chk("rst_cfg", RST_PORT_CFG, rd_data[7:0]);
    xfer(1'b1, 2'h0, ADDR_FORMAT, 32'h0);
    chk("rst_fmt_reg", RST_FORMAT, rd_data[7:0]);
    xfer(1'b1, 2'h3, 8'h20, 32'h0);
    chk("ram_kept", 32'hdead_beef, rd_data);
    xfer(1'b0, 2'h0, ADDR_FORMAT, 32'h1);
    xfer(1'b0, 2'h0, ADDR_UPDATE, 32'h1);
    chk("fmt_set", 1'b1, nfs);
    // Both soft reset bits set; the mirrored byte lands in either order
    xfer(1'b0, 2'h0, ADDR_PORT_CFG, 32'h24);
    chk("soft_fmt", 1'b0, nfs);
    xfer(1'b1, 2'h0, ADDR_FORMAT, 32'h0);
    chk("soft_shadow", RST_FORMAT, rd_data[7:0]);
    print_verdict();
  end
endmodule : ccsp_bench
`default_nettype wire

// >>> tb/ccsp_link_props.sv
// Protocol checks on the three-wire link between master and device
`timescale 1ns/10ps
`default_nettype none
module ccsp_link_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic port_select_n,
  input wire logic serial_clock_format_strap,
  input wire logic mst_io_o,
  input wire logic mst_io_oe,
  input wire logic dev_io_o,
  input wire logic dev_io_oe,
  input wire logic serial_io_stabilizer_strap
);
  logic sclk_ff;
  logic [5:0] rise_cnt_ff;

  // Rising serial clock edges seen in the current frame
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_ff <= 1'b0;
      rise_cnt_ff <= 6'h0;
    end else begin
      sclk_ff <= serial_clock_format_strap;
      if (port_select_n) begin
        rise_cnt_ff <= 6'h0;
      end else if (serial_clock_format_strap && !sclk_ff) begin
        rise_cnt_ff <= rise_cnt_ff + 6'h1;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Device lets go a few cycles after select rises, then stays off
  chk_idle_quiet: assert property (port_select_n [*5] |-> !dev_io_oe)
    else $error("device drives data while deselected");
  chk_sclk_idle: assert property (port_select_n |-> !serial_clock_format_strap && !mst_io_oe)
    else $error("clock or master data active outside frame");
  chk_no_fight: assert property (!(mst_io_oe && dev_io_oe))
    else $error("both ends drive the data line");
  chk_instr_len: assert property ($rose(dev_io_oe) |-> rise_cnt_ff == 6'h10)
    else $error("read turnaround not after sixteen instruction bits");
  chk_frame_bytes: assert property ($rose(port_select_n)
    |-> rise_cnt_ff inside {6'h18, 6'h20, 6'h28, 6'h30})
    else $error("frame is not instruction plus whole bytes");
  chk_drive_fall: assert property ($rose(dev_io_oe) |-> !serial_clock_format_strap)
    else $error("device starts driving outside clock low phase");
  chk_release_rise: assert property ($fell(dev_io_oe)
    |-> serial_clock_format_strap || port_select_n)
    else $error("device releases line outside clock high phase");
  chk_dev_bit_hold: assert property (dev_io_oe && serial_clock_format_strap
    && $past(serial_clock_format_strap) |-> $stable(dev_io_o))
    else $error("device data moves while clock high");
  chk_mst_bit_hold: assert property (mst_io_oe && $past(mst_io_oe) && serial_clock_format_strap
    && $past(serial_clock_format_strap) |-> $stable(mst_io_o))
    else $error("master data moves while clock high");
endmodule : ccsp_link_props
`default_nettype wire
